/* File: lfc_pkg.sv */
// Notes on behaviour
// [R01] Flags bound frames; zero bits stuffed, removed.
// [R02] At least two flags between frames.
// [R03] Frames hold whole octets; others invalid.
// [R04] Octets ascending, each sent LSB first.
// [R05] Append and check 16-bit CRC.
// [R06] Address, control, optional info, CRC; info limit.
// [R07] First address EA zero, second one.
// [R08] SAPI and TEI form 13-bit link id.
// [R09] User side: commands C/R 0, responses 1.
// [R10] Control two octets when numbered, else one.
// [R11] S frames: RR, RNR, REJ codes plus N(R).
// [R12] U frames: one octet, P/F in bit 5.
// [R13] P/F is poll in commands, final otherwise.
// [R14] I frames: N(S), zero, N(R), P.
// [R15] Supervisory reserved bits sent as zero.
// [R16] Parallel mode: no stuffing, pins delimit frames.
// [R17] Send delimiter on RTS, receive on CTS.
// [R18] NRZ data on separate external line clocks.
// [R19] Network side uses inverted C/R polarity.
// [R20] CRC-CCITT, preset ones, complement sent.
package lfc_pkg;
    // Line patterns.
    localparam logic [7:0] LFC_FLAG = 8'h7E;
    localparam logic [7:0] LFC_ABORT = 8'hFF;
    localparam logic [7:0] LFC_PAR_IDLE = 8'h00;
    // Check sequence constants, bit-reversed form for LSB-first shifting.
    localparam logic [15:0] LFC_CRC_INIT = 16'hFFFF;
    localparam logic [15:0] LFC_CRC_POLY = 16'h8408;
    localparam logic [15:0] LFC_CRC_GOOD = 16'hF0B8;
    // Run lengths of ones that trigger stuffing and flag detection, and the last bit index of an octet.
    localparam logic [2:0] LFC_ONES_STUFF = 3'h5;
    localparam logic [2:0] LFC_ONES_FLAG = 3'h6;
    localparam logic [2:0] LFC_BIT_LAST = 3'h7;
    // Partial bits left in the receive shifter at the end of a good frame.
    localparam logic [2:0] LFC_TAIL_SERIAL = 3'h6;
    localparam logic [2:0] LFC_TAIL_PAR = 3'h0;
    // Header lengths: address plus one or two control octets.
    localparam logic [2:0] LFC_HDR_SHORT = 3'h3;
    localparam logic [2:0] LFC_HDR_LONG = 3'h4;
    // Information limits and the worst-case framing overhead.
    localparam logic [8:0] LFC_INFO_SHORT = 9'h080;
    localparam logic [8:0] LFC_INFO_LONG = 9'h104;
    localparam logic [8:0] LFC_OVERHEAD = 9'h006;
    // Frame types.
    localparam logic [1:0] LFC_TYPE_I = 2'h0;
    localparam logic [1:0] LFC_TYPE_S = 2'h1;
    localparam logic [1:0] LFC_TYPE_U = 2'h2;
    // Supervisory first octets, indexed RR, RNR, REJ; reserved bits zero.
    localparam logic [7:0] LFC_S_CODE [0:3] = '{8'h01, 8'h05, 8'h09, 8'h01};
    // Unnumbered octets with P/F clear: SABME DM UI DISC UA FRMR XID.
    localparam logic [7:0] LFC_U_CODE [0:7] =
        '{8'h6F, 8'h0F, 8'h03, 8'h43, 8'h63, 8'h87, 8'hAF, 8'h03};
    localparam int LFC_U_PF_BIT = 4;
    // Transmit buffer shape.
    localparam int LFC_BUF_DEPTH = 2;
    localparam int LFC_BUF_W = 9;
    // Transmit sequencer states.
    typedef enum logic [4:0] {
        LFC_TX_IDLE = 5'h01,
        LFC_TX_HDR = 5'h02,
        LFC_TX_DATA = 5'h04,
        LFC_TX_CRC = 5'h08,
        LFC_TX_CLOSE = 5'h10
    } lfc_tx_state_t;

    // Advances the check sequence by one octet, LSB first.
    function automatic logic [15:0] lfc_crc_byte(input logic [15:0] crc,
                                                 input logic [7:0] data);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ data[i]) ? LFC_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : lfc_crc_byte
endpackage : lfc_pkg

/* File: lfc_frame_codec.sv */
`timescale 1ns/100ps
module lfc_frame_codec (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Configuration levels.
    input wire logic i_parallel_mode,
    input wire logic i_network_side,
    input wire logic i_info_long,
    // Line pins.
    input wire logic i_tx_clk,
    input wire logic i_rx_clk,
    input wire logic i_rx_data,
    input wire logic i_rx_frame_delimit,
    output logic o_tx_data,
    output logic o_tx_frame_delimit,
    // Transmit frame request and header fields.
    input wire logic i_tx_req,
    input wire logic [1:0] i_tx_type,
    input wire logic [2:0] i_tx_fn,
    input wire logic i_tx_cmd,
    input wire logic i_tx_pf,
    input wire logic [5:0] i_tx_sapi,
    input wire logic [6:0] i_tx_tei,
    input wire logic [6:0] i_tx_ns,
    input wire logic [6:0] i_tx_nr,
    input wire logic i_tx_has_info,
    output logic o_tx_ack,
    output logic o_tx_underrun,
    // Transmit information stream.
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_tx_last,
    output logic o_tx_ready,
    // Receive octet stream and frame status.
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_rx_end,
    output logic o_rx_crc_ok,
    output logic o_rx_bad_len,
    output logic o_rx_too_long,
    output logic o_rx_bad_addr,
    output logic [12:0] o_rx_llid,
    output logic o_rx_cmd,
    output logic o_rx_poll,
    output logic o_rx_final
);

    // Synchronisers: 0 tx clock, 1 rx clock, 2 rx data, 3 rx delimiter.
    logic [3:0] sync1;
    logic [3:0] sync2;
    // Previous synchronised clock levels for edge detection.
    logic [1:0] clk_prev;

    // Two flip-flops per line input before any logic looks at them.
    always_ff @(posedge i_sys_clk) begin
        sync1 <= {i_rx_frame_delimit, i_rx_data, i_rx_clk, i_tx_clk};
        sync2 <= sync1;
        clk_prev <= sync2[1:0];
    end

    // Transmit shifts on the falling edge, receive samples on the rising edge.
    // [R18] NRZ line timing
    wire tx_tick = clk_prev[0] & ~sync2[0];
    wire rx_tick = ~clk_prev[1] & sync2[1];
    wire rxd = sync2[2];
    wire rx_dlm = sync2[3];

    // Transmit buffer storage and pointers.
    logic [lfc_pkg::LFC_BUF_W-1:0] buf_mem [0:lfc_pkg::LFC_BUF_DEPTH-1];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic buf_pop;
    wire buf_push = i_tx_valid & o_tx_ready;
    wire buf_valid = (buf_cnt != 2'h0);
    wire [7:0] buf_byte = buf_mem[buf_rp][7:0];
    wire buf_last = buf_mem[buf_rp][8];
    wire [1:0] next_buf_cnt = buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};

    // Two-entry buffer; the serialiser drains only at octet boundaries.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            o_tx_ready <= 1'b0;
        end else begin
            buf_wp <= buf_wp ^ buf_push;
            buf_rp <= buf_rp ^ buf_pop;
            buf_cnt <= next_buf_cnt;
            o_tx_ready <= (next_buf_cnt != 2'(lfc_pkg::LFC_BUF_DEPTH));
        end
    end

    // Storage write, no reset needed for data.
    always_ff @(posedge i_sys_clk) begin
        if (buf_push) begin
            buf_mem[buf_wp] <= {i_tx_last, i_tx_byte};
        end
    end

    // Transmit sequencer registers.
    lfc_pkg::lfc_tx_state_t tx_state;
    lfc_pkg::lfc_tx_state_t next_state;
    logic [7:0] tx_sh;
    logic [2:0] tx_bcnt;
    logic [2:0] tx_ones;
    logic tx_stf;
    logic [2:0] tx_idx;
    logic idle_done;
    logic [15:0] tx_crc;
    // Header fields held for the whole frame.
    logic [1:0] f_type;
    logic [2:0] f_fn;
    logic f_cmd;
    logic f_pf;
    logic [5:0] f_sapi;
    logic [6:0] f_tei;
    logic [6:0] f_ns;
    logic [6:0] f_nr;
    logic f_info;

    // Stuffing is suppressed entirely in parallel mode.
    // [R16] no zero insertion
    wire stuff_now = ~i_parallel_mode & (tx_ones == lfc_pkg::LFC_ONES_STUFF);
    wire byte_end = tx_tick & ~stuff_now & (tx_bcnt == lfc_pkg::LFC_BIT_LAST);
    wire [7:0] gap_byte = i_parallel_mode ? lfc_pkg::LFC_PAR_IDLE : lfc_pkg::LFC_FLAG;
    // [R09] user side polarity
    // [R19] network side inverted
    wire tx_cr = f_cmd ~^ i_network_side;
    // [R07] address extension bits
    wire [7:0] addr1 = {f_sapi, tx_cr, 1'b0};
    wire [7:0] addr2 = {f_tei, 1'b1};
    // [R14] information control octets
    wire [7:0] ctl_i = {f_ns, 1'b0};
    // [R11] supervisory codes
    // [R15] reserved bits zero
    wire [7:0] ctl_s = lfc_pkg::LFC_S_CODE[f_fn[1:0]];
    // [R12] unnumbered codes
    wire [7:0] ctl_u = lfc_pkg::LFC_U_CODE[f_fn] | (8'({f_pf}) << lfc_pkg::LFC_U_PF_BIT);
    wire [7:0] ctl1 = (f_type == lfc_pkg::LFC_TYPE_I) ? ctl_i :
                      (f_type == lfc_pkg::LFC_TYPE_S) ? ctl_s : ctl_u;
    wire [7:0] ctl2 = {f_nr, f_pf};
    // [R10] control field length
    wire [2:0] hdr_len = (f_type == lfc_pkg::LFC_TYPE_U) ? lfc_pkg::LFC_HDR_SHORT :
                         lfc_pkg::LFC_HDR_LONG;
    wire [7:0] hdr_byte = (tx_idx == 3'h1) ? addr2 : (tx_idx == 3'h2) ? ctl1 : ctl2;

    // Decisions taken at each octet boundary.
    logic [7:0] next_byte;
    logic next_stf;
    logic [2:0] next_idx;
    logic take;
    logic unr;
    logic crc_upd;

    // Picks the next octet, its stuffing and the next state.
    always_comb begin
        next_state = tx_state;
        next_byte = gap_byte;
        next_stf = 1'b0;
        next_idx = tx_idx;
        take = 1'b0;
        unr = 1'b0;
        crc_upd = 1'b0;
        buf_pop = 1'b0;
        case (tx_state)
            lfc_pkg::LFC_TX_IDLE: begin
                // [R02] two flags between frames
                if (byte_end && idle_done && i_tx_req) begin
                    take = 1'b1;
                    next_state = lfc_pkg::LFC_TX_HDR;
                    next_byte = addr1;
                    next_stf = 1'b1;
                    next_idx = 3'h1;
                end
            end
            lfc_pkg::LFC_TX_HDR: begin
                next_stf = 1'b1;
                if (tx_idx != hdr_len) begin
                    // [R04] ascending octet order
                    next_byte = hdr_byte;
                    next_idx = tx_idx + 3'h1;
                    crc_upd = 1'b1;
                    if (f_info && next_idx == hdr_len) begin
                        // Last header octet loaded; the stream octets follow it directly.
                        next_state = lfc_pkg::LFC_TX_DATA;
                    end
                end else begin
                    // Frame without information goes straight to the check.
                    next_state = lfc_pkg::LFC_TX_CRC;
                    next_byte = ~tx_crc[7:0];
                    next_idx = 3'h1;
                end
            end
            lfc_pkg::LFC_TX_DATA: begin
                next_idx = 3'h0;
                if (buf_valid) begin
                    buf_pop = byte_end;
                    next_byte = buf_byte;
                    next_stf = 1'b1;
                    crc_upd = 1'b1;
                    next_state = buf_last ? lfc_pkg::LFC_TX_CRC : lfc_pkg::LFC_TX_DATA;
                end else begin
                    // Starved stream: abort the frame on the line.
                    unr = byte_end;
                    next_byte = i_parallel_mode ? lfc_pkg::LFC_PAR_IDLE : lfc_pkg::LFC_ABORT;
                    next_state = lfc_pkg::LFC_TX_CLOSE;
                end
            end
            lfc_pkg::LFC_TX_CRC: begin
                // [R05] check sequence, high term first
                // [R20] complemented remainder
                next_stf = (tx_idx != 3'h2);
                next_idx = tx_idx + 3'h1;
                next_byte = (tx_idx == 3'h0) ? ~tx_crc[7:0] :
                            (tx_idx == 3'h1) ? ~tx_crc[15:8] : gap_byte;
                if (tx_idx == 3'h2) begin
                    // [R01] closing flag
                    next_state = lfc_pkg::LFC_TX_CLOSE;
                end
            end
            lfc_pkg::LFC_TX_CLOSE: begin
                next_state = lfc_pkg::LFC_TX_IDLE;
            end
            default: begin
                next_state = lfc_pkg::LFC_TX_IDLE;
            end
        endcase
    end

    // Header fields follow the inputs while idle and freeze once taken.
    always_ff @(posedge i_sys_clk) begin
        if (tx_state == lfc_pkg::LFC_TX_IDLE && !take) begin
            f_type <= i_tx_type;
            f_fn <= i_tx_fn;
            f_cmd <= i_tx_cmd;
            f_pf <= i_tx_pf;
            f_sapi <= i_tx_sapi;
            f_tei <= i_tx_tei;
            f_ns <= i_tx_ns;
            f_nr <= i_tx_nr;
            f_info <= i_tx_has_info;
        end
    end

    // Serialiser: one bit per transmit clock, stuffed zero when due.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tx_state <= lfc_pkg::LFC_TX_IDLE;
            tx_sh <= lfc_pkg::LFC_FLAG;
            tx_bcnt <= 3'h0;
            tx_ones <= 3'h0;
            tx_stf <= 1'b0;
            tx_idx <= 3'h0;
            idle_done <= 1'b0;
            tx_crc <= lfc_pkg::LFC_CRC_INIT;
            o_tx_data <= 1'b1;
            o_tx_frame_delimit <= 1'b0;
            o_tx_ack <= 1'b0;
            o_tx_underrun <= 1'b0;
        end else begin
            o_tx_ack <= take;
            o_tx_underrun <= unr;
            if (tx_tick) begin
                // [R17] delimiter marks frame bits in parallel mode, held high in serial mode
                o_tx_frame_delimit <= ~i_parallel_mode | tx_stf;
            end
            if (tx_tick && stuff_now) begin
                // [R01] insert zero after five ones
                o_tx_data <= 1'b0;
                tx_ones <= 3'h0;
            end else if (tx_tick) begin
                o_tx_data <= tx_sh[0];
                tx_ones <= (tx_stf & tx_sh[0]) ? tx_ones + 3'h1 : 3'h0;
                tx_bcnt <= tx_bcnt + 3'h1;
                tx_sh <= {1'b0, tx_sh[7:1]};
            end
            if (byte_end) begin
                tx_state <= next_state;
                tx_sh <= next_byte;
                tx_stf <= next_stf;
                tx_idx <= next_idx;
                idle_done <= (tx_state == lfc_pkg::LFC_TX_IDLE && !take) ||
                             (tx_state == lfc_pkg::LFC_TX_CLOSE);
                if (take) begin
                    tx_crc <= lfc_pkg::lfc_crc_byte(lfc_pkg::LFC_CRC_INIT, next_byte);
                end else if (crc_upd) begin
                    tx_crc <= lfc_pkg::lfc_crc_byte(tx_crc, next_byte);
                end
            end
        end
    end

    // Receive state.
    logic rx_in;
    logic [2:0] rx_ones;
    logic [7:0] rx_acc;
    logic [2:0] rx_acnt;
    logic [8:0] rx_nbytes;
    logic [15:0] rx_crc;
    logic [1:0] rx_held;
    logic [7:0] rx_h0;
    logic [7:0] rx_h1;
    logic [7:0] rx_a0;
    logic [7:0] rx_a1;
    logic [7:0] rx_c1;
    logic [7:0] rx_c2;

    // Line events for the serial and parallel framings.
    // [R01] flag and stuffed zero detection
    wire s_flag = ~rxd & (rx_ones == lfc_pkg::LFC_ONES_FLAG);
    wire s_abort = rxd & (rx_ones == lfc_pkg::LFC_ONES_FLAG);
    wire s_stuffed = ~rxd & (rx_ones == lfc_pkg::LFC_ONES_STUFF);
    wire s_add = rx_in & ~s_stuffed & ~(rxd & (rx_ones >= lfc_pkg::LFC_ONES_STUFF));
    // [R16] delimiter pin frames data
    // [R17] receive delimiter input
    wire add_bit = rx_tick & (i_parallel_mode ? rx_dlm : s_add);
    wire end_evt = rx_tick & rx_in & (i_parallel_mode ? ~rx_dlm : s_flag);
    wire start_evt = rx_tick & (i_parallel_mode ? (rx_dlm & ~rx_in) : s_flag);
    wire [7:0] oct = {rxd, rx_acc[7:1]};
    wire oct_done = add_bit & (rx_acnt == lfc_pkg::LFC_BIT_LAST);
    wire [2:0] tail = i_parallel_mode ? lfc_pkg::LFC_TAIL_PAR : lfc_pkg::LFC_TAIL_SERIAL;
    // [R06] information length limit
    wire [8:0] max_len = (i_info_long ? lfc_pkg::LFC_INFO_LONG : lfc_pkg::LFC_INFO_SHORT) +
                         lfc_pkg::LFC_OVERHEAD;
    // [R13] P/F from U octet or second octet
    wire rx_pf = (rx_c1[1:0] == 2'h3) ? rx_c1[lfc_pkg::LFC_U_PF_BIT] : rx_c2[0];
    wire rx_is_cmd = rx_a0[1] ^ i_network_side;

    // Deframer: assembles octets, holds back two as the check field.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rx_in <= 1'b0;
            rx_ones <= 3'h0;
            rx_acc <= 8'h00;
            rx_acnt <= 3'h0;
            rx_nbytes <= 9'h000;
            rx_crc <= lfc_pkg::LFC_CRC_INIT;
            rx_held <= 2'h0;
            rx_h0 <= 8'h00;
            rx_h1 <= 8'h00;
            rx_a0 <= 8'h00;
            rx_a1 <= 8'h00;
            rx_c1 <= 8'h00;
            rx_c2 <= 8'h00;
            o_rx_valid <= 1'b0;
            o_rx_byte <= 8'h00;
            o_rx_end <= 1'b0;
            o_rx_crc_ok <= 1'b0;
            o_rx_bad_len <= 1'b0;
            o_rx_too_long <= 1'b0;
            o_rx_bad_addr <= 1'b0;
            o_rx_llid <= 13'h0000;
            o_rx_cmd <= 1'b0;
            o_rx_poll <= 1'b0;
            o_rx_final <= 1'b0;
        end else begin
            o_rx_valid <= 1'b0;
            o_rx_end <= 1'b0;
            if (rx_tick) begin
                rx_ones <= rxd ? ((rx_ones == lfc_pkg::LFC_BIT_LAST) ? rx_ones : rx_ones + 3'h1)
                               : 3'h0;
            end
            if (add_bit) begin
                // [R04] LSB first assembly
                rx_acc <= oct;
                rx_acnt <= rx_acnt + 3'h1;
            end
            if (oct_done) begin
                // [R05] running check over every octet
                rx_crc <= lfc_pkg::lfc_crc_byte(rx_crc, oct);
                rx_nbytes <= (rx_nbytes == 9'h1FF) ? rx_nbytes : rx_nbytes + 9'h001;
                rx_a0 <= (rx_nbytes == 9'h000) ? oct : rx_a0;
                rx_a1 <= (rx_nbytes == 9'h001) ? oct : rx_a1;
                rx_c1 <= (rx_nbytes == 9'h002) ? oct : rx_c1;
                rx_c2 <= (rx_nbytes == 9'h003) ? oct : rx_c2;
                rx_h0 <= (rx_held == 2'h2) ? rx_h1 : ((rx_held == 2'h0) ? oct : rx_h0);
                rx_h1 <= (rx_held == 2'h0) ? rx_h1 : oct;
                rx_held <= (rx_held == 2'h2) ? rx_held : rx_held + 2'h1;
                o_rx_valid <= (rx_held == 2'h2);
                o_rx_byte <= rx_h0;
            end
            if (end_evt && rx_nbytes != 9'h000) begin
                o_rx_end <= 1'b1;
                o_rx_crc_ok <= (rx_crc == lfc_pkg::LFC_CRC_GOOD);
                // [R03] whole octets only
                o_rx_bad_len <= (rx_acnt != tail);
                o_rx_too_long <= (rx_nbytes > max_len);
                // [R07] extension bit check
                o_rx_bad_addr <= rx_a0[0] | ~rx_a1[0];
                // [R08] combined link identifier
                o_rx_llid <= {rx_a0[7:2], rx_a1[7:1]};
                o_rx_cmd <= rx_is_cmd;
                // [R13] poll versus final
                o_rx_poll <= rx_pf & rx_is_cmd;
                o_rx_final <= rx_pf & ~rx_is_cmd;
            end
            if (end_evt || start_evt || (rx_tick && s_abort && !i_parallel_mode)) begin
                // New frame or drop: reset the bit, octet and held counts and the check; the run of ones keeps counting.
                rx_in <= start_evt | (end_evt & ~i_parallel_mode);
                rx_acnt <= (start_evt && i_parallel_mode) ? 3'h1 : 3'h0;
                rx_acc <= oct;
                rx_nbytes <= 9'h000;
                rx_crc <= lfc_pkg::LFC_CRC_INIT;
                rx_held <= 2'h0;
            end
        end
    end

endmodule : lfc_frame_codec

/* File: lfc_phy_model.sv */
`timescale 1ns/100ps
module lfc_phy_model (
    // Line from the codec.
    input wire logic i_tx_data,
    input wire logic i_tx_frame_delimit,
    // Line clocks and data toward the codec.
    output logic o_tx_clk,
    output logic o_rx_clk,
    output logic o_rx_data,
    output logic o_rx_frame_delimit
);
    // Separate line clock.
    // The line idles as flags, or as zero octets in parallel mode; this clock keeps running between frames.
    initial begin
        o_tx_clk = 1'b1;
        #3.3;
        forever #62.5 o_tx_clk = ~o_tx_clk;
    end
    // Line looped back.
    // The receive pins see the transmit pins late, so the codec hears itself.
    assign #20 o_rx_clk = o_tx_clk;
    assign #20 o_rx_data = i_tx_data;
    assign #20 o_rx_frame_delimit = i_tx_frame_delimit;
endmodule : lfc_phy_model

/* File: lfc_frame_codec_monitor.sv */
`timescale 1ns/100ps
module lfc_frame_codec_monitor (
    // Clock, reset and mode.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_parallel_mode,
    // Transmit side.
    input wire logic i_tx_req,
    input wire logic i_tx_valid,
    input wire logic o_tx_ack,
    input wire logic o_tx_underrun,
    input wire logic o_tx_ready,
    input wire logic o_tx_frame_delimit,
    // Receive side.
    input wire logic o_rx_valid,
    input wire logic o_rx_end,
    input wire logic o_rx_cmd,
    input wire logic o_rx_poll,
    input wire logic o_rx_final
);
    // All checks run on the system clock and rest during reset.
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // Pushes into the buffer on two cycles in a row.
    sequence s_two_push;
        (i_tx_valid && o_tx_ready) ##1 (i_tx_valid && o_tx_ready);
    endsequence
    // No further ack for eight cycles.
    sequence s_ack_quiet;
        (!o_tx_ack)[*8];
    endsequence
    property p_ack_req; o_tx_ack |-> $past(i_tx_req) ##1 s_ack_quiet; endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    property p_under_gap; o_tx_underrun |=> (!o_tx_underrun)[*8]; endproperty
    a_under_gap: assert property (p_under_gap) else $error("underrun too long");
    property p_rx_gap; o_rx_valid |=> (!o_rx_valid)[*8]; endproperty
    a_rx_gap: assert property (p_rx_gap) else $error("octets too close");
    property p_end_gap; o_rx_end |=> (!o_rx_end && !o_rx_valid)[*8]; endproperty
    a_end_gap: assert property (p_end_gap) else $error("frame end too close");
    property p_poll; o_rx_poll |-> o_rx_cmd && !o_rx_final; endproperty
    a_poll: assert property (p_poll) else $error("poll on a response");
    property p_final; o_rx_final |-> !o_rx_cmd; endproperty
    a_final: assert property (p_final) else $error("final on a command");
    property p_delim; !i_parallel_mode && o_tx_frame_delimit |=> o_tx_frame_delimit; endproperty
    a_delim: assert property (p_delim) else $error("serial delimiter dropped");
    property p_buf_full; s_two_push |=> !o_tx_ready; endproperty
    a_buf_full: assert property (p_buf_full) else $error("buffer overfilled");
endmodule : lfc_frame_codec_monitor
bind lfc_frame_codec lfc_frame_codec_monitor u_monitor (.*);

/* File: lfc_frame_codec_test.sv */
`timescale 1ns/100ps
module lfc_frame_codec_test;
    // Design pins, named as the ports so the instance connects by name.
    logic i_sys_clk, i_rst, i_parallel_mode, i_network_side, i_info_long, i_tx_clk, i_rx_clk;
    logic i_rx_data, i_rx_frame_delimit, o_tx_data, o_tx_frame_delimit, i_tx_req, i_tx_cmd;
    logic i_tx_pf, i_tx_has_info, o_tx_ack, o_tx_underrun, i_tx_valid, i_tx_last, o_tx_ready;
    logic o_rx_valid, o_rx_end, o_rx_crc_ok, o_rx_bad_len, o_rx_too_long, o_rx_bad_addr;
    logic o_rx_cmd, o_rx_poll, o_rx_final, took;
    logic [1:0] i_tx_type;
    logic [2:0] i_tx_fn;
    logic [5:0] i_tx_sapi;
    logic [6:0] i_tx_tei, i_tx_ns, i_tx_nr;
    logic [7:0] i_tx_byte, o_rx_byte;
    logic [12:0] o_rx_llid;
    // Tallies, captured octets and the stream to send.
    int err_count, cmp_count, ends, acks, unders;
    logic [7:0] got[$];
    logic [7:0] info[$];
    // Unnumbered octets with P/F clear, in function order.
    logic [7:0] ucode [0:6] = '{8'h6F, 8'h0F, 8'h03, 8'h43, 8'h63, 8'h87, 8'hAF};
    lfc_frame_codec dut (.*);
    lfc_phy_model u_phy (.i_tx_data(o_tx_data), .i_tx_frame_delimit(o_tx_frame_delimit),
        .o_tx_clk(i_tx_clk), .o_rx_clk(i_rx_clk), .o_rx_data(i_rx_data),
        .o_rx_frame_delimit(i_rx_frame_delimit));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // Records octets, frame ends, acks, underruns and buffer pushes.
    always @(posedge i_sys_clk) begin
        took <= i_tx_valid & o_tx_ready;
        if (o_rx_valid === 1'b1) got.push_back(o_rx_byte);
        if (o_rx_end === 1'b1) ends++;
        if (o_tx_ack === 1'b1) acks++;
        if (o_tx_underrun === 1'b1) unders++;
    end
    // Compares one value, counting it and reporting a difference at once.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Prints the tallies and the verdict, then ends the run.
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    // Holds reset for four cycles and sets the mode while it is held.
    task automatic do_reset(input logic par);
        @(negedge i_sys_clk);
        {i_rst, i_parallel_mode, i_info_long} = {1'b1, par, par};
        repeat (4) @(negedge i_sys_clk);
        i_rst = 1'b0;
    endtask : do_reset
    // Sends one frame round the loop, then judges the octets and the status.
    task automatic frame(input logic [1:0] ty, input logic [2:0] fn, input logic cmd,
            input logic pf, input logic has);
        logic [7:0] exp[$];
        int k, idx, a, e;
        {a, e, idx} = {acks, ends, 32'h0};
        got = {};
        exp.push_back({i_tx_sapi, ~(cmd ^ i_network_side), 1'b0});
        exp.push_back({i_tx_tei, 1'b1});
        if (ty == 2'h2) exp.push_back(ucode[fn] | {3'h0, pf, 4'h0});
        else exp.push_back(ty == 2'h0 ? {i_tx_ns, 1'b0} : {4'h0, fn[1:0], 2'h1});
        if (ty != 2'h2) exp.push_back({i_tx_nr, pf});
        foreach (info[i]) exp.push_back(info[i]);
        @(negedge i_sys_clk);
        {i_tx_type, i_tx_fn, i_tx_cmd, i_tx_pf, i_tx_has_info} = {ty, fn, cmd, pf, has};
        @(negedge i_sys_clk);
        i_tx_req = 1'b1;
        // Holds the request until taken and feeds the stream as the buffer accepts.
        for (k = 0; k < 6000 && (acks == a || idx < info.size()); k++) begin
            @(negedge i_sys_clk);
            if (took === 1'b1) idx++;
            if (acks != a) i_tx_req = 1'b0;
            i_tx_valid = (idx < info.size());
            i_tx_byte = info[idx];
            i_tx_last = (idx == info.size() - 1);
        end
        if (has && info.size() == 0) return;
        for (k = 0; k < 6000 && ends == e; k++) @(negedge i_sys_clk);
        check("frame end count", 16'(ends - e), 16'h0001);
        if (ends == e) summarize();
        check("octet count", 16'(got.size()), 16'(exp.size()));
        foreach (exp[i]) check("octet", got[i], exp[i]);
        check("status", {o_rx_crc_ok, o_rx_bad_len, o_rx_too_long, o_rx_bad_addr}, 4'h8);
        check("link id", o_rx_llid, {i_tx_sapi, i_tx_tei});
        // Looped back, the side hears its own command as a response and vice versa.
        check("cr flags", {o_rx_cmd, o_rx_poll, o_rx_final}, {~cmd, ~cmd & pf, cmd & pf});
    endtask : frame
    // Every supervisory and unnumbered function at boundary field values.
    task automatic s_codes;
        info = {};
        {i_tx_sapi, i_tx_tei, i_tx_nr} = {6'h3F, 7'h00, 7'h7F};
        for (int f = 0; f < 7; f++) begin
            if (f < 3) frame(2'h1, f[2:0], f[0], 1'b1, 1'b0);
            frame(2'h2, f[2:0], f[1], f[0], 1'b0);
        end
    endtask : s_codes
    // Numbered frame with octets that need stuffing, serial or parallel.
    task automatic s_info(input logic par);
        do_reset(par);
        {i_network_side, i_tx_ns, i_tx_sapi, i_tx_tei} = {~par, 7'h7F, 6'h15, 7'h2A};
        info = '{8'h7E, 8'hFF, 8'h00, 8'hF8};
        frame(2'h0, 3'h0, 1'b1, 1'b1, 1'b1);
    endtask : s_info
    // A frame whose stream stays empty is cut short without a frame end.
    task automatic s_underrun;
        int k, e, u;
        {e, u} = {ends, unders};
        info = {};
        frame(2'h0, 3'h0, 1'b0, 1'b0, 1'b1);
        for (k = 0; k < 3000 && unders == u; k++) @(negedge i_sys_clk);
        repeat (400) @(negedge i_sys_clk);
        check("underrun count", 16'(unders - u), 16'h0001);
        check("aborted frame end count", 16'(ends - e), 16'h0000);
    endtask : s_underrun
    // Main sequence.
    initial begin
        {i_rst, i_parallel_mode, i_network_side, i_info_long, i_tx_req, i_tx_cmd} = 6'h20;
        {i_tx_pf, i_tx_has_info, i_tx_valid, i_tx_last, i_tx_type, i_tx_fn} = 9'h000;
        {i_tx_sapi, i_tx_tei, i_tx_ns, i_tx_nr, i_tx_byte} = 35'h0;
        do_reset(1'b0);
        s_codes();
        s_info(1'b0);
        s_underrun();
        s_info(1'b1);
        summarize();
    end
endmodule : lfc_frame_codec_test
